// file: design/csr_status_top.sv
// condition registers, error list, status byte and device clear
// assumes query and clear strobes are one-cycle pulses from the interface parser
`timescale 1ns/1ns
module csr_status_top
    import csr_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 seq_running_i,
    input  wire logic                 overtemp_shutdown_i,
    input  wire logic                 overtemp_warning_i,
    input  wire logic                 overvoltage_prot_i,
    input  wire logic                 overcurrent_prot_i,
    input  wire logic                 overload_i,
    input  wire logic                 current_regulation_i,
    input  wire logic                 voltage_regulation_i,
    input  wire logic                 selftest_or_calibration_i,
    input  wire logic                 trigger_input_two_i,
    input  wire logic                 trigger_input_one_i,
    input  wire logic                 mains_low_i,
    input  wire logic [2:0]           signal_outputs_i,
    input  wire logic                 current_band_violation_i,
    input  wire logic                 voltage_band_violation_i,
    input  wire logic                 limit_monitor_enable_i,
    input  wire logic                 query_i,
    input  wire csr_query_t           query_sel_i,
    input  wire logic                 text_clear_i,
    input  wire logic                 bus_sdc_i,
    input  wire logic                 bus_dcl_i,
    input  wire logic                 clear_status_i,
    input  wire logic                 err_valid_i,
    input  wire logic [7:0]           err_code_i,
    input  wire logic [7:0]           reset_source_register_i,
    input  wire logic                 msg_set_i,
    input  wire logic                 msg_drained_i,
    input  wire logic                 status_summary_i,
    input  wire logic                 srq_set_i,
    input  wire logic                 serial_poll_done_i,
    output logic                      resp_valid_o,
    output logic      [7:0]           resp_data_o,
    output logic      [31:0]          resp_err_list_o,
    output logic                      buf_flush_o,
    output logic                      ready_o,
    output logic                      message_available_bit_o,
    output logic                      srq_o,
    output logic      [7:0]           status_byte_o
);
    logic [7:0]  cond_a;
    logic [7:0]  cond_b;
    logic [7:0]  raw_a;
    logic [7:0]  raw_b;
    logic [23:0] err_slots;
    logic        dev_clear;

    logic        resp_valid_r, resp_valid_nxt;
    logic [7:0]  resp_data_r, resp_data_nxt;
    logic [31:0] resp_err_r, resp_err_nxt;
    logic        flush_r, flush_nxt;
    logic        ready_r, ready_nxt;
    logic        mav_r, mav_nxt;
    logic        srq_r, srq_nxt;
    logic        summ_r, summ_nxt;
    logic [7:0]  stb;

    assign raw_a = {seq_running_i, overtemp_shutdown_i, overtemp_warning_i,
                    overvoltage_prot_i, overcurrent_prot_i, overload_i,
                    current_regulation_i, voltage_regulation_i};
    assign raw_b = {selftest_or_calibration_i, trigger_input_two_i,
                    trigger_input_one_i, mains_low_i, 1'b0,
                    |signal_outputs_i, current_band_violation_i,
                    voltage_band_violation_i};

    csr_cond_regs u_cond
    (
        .core_clk_i             (core_clk_i),
        .rst_b_i                (rst_b_i),
        .cond_a_raw_i           (raw_a),
        .cond_b_raw_i           (raw_b),
        .limit_monitor_enable_i (limit_monitor_enable_i),
        .cond_a_o               (cond_a),
        .cond_b_o               (cond_b)
    );

    csr_error_list u_err
    (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .err_valid_i (err_valid_i),
        .err_code_i  (err_code_i),
        .clear_i     (clear_status_i),
        .slots_o     (err_slots)
    );

    assign dev_clear = text_clear_i | bus_sdc_i | bus_dcl_i;

    // status byte: summary bit, message available, request service
    always_comb
    begin
        stb = STB_RESET;
        stb[STB_MAV_BIT] = mav_r;
        stb[STB_RQS_BIT] = srq_r;
        stb[CRA_CV_BIT]  = summ_r;
    end

    always_comb
    begin
        resp_valid_nxt = 1'b0;
        resp_data_nxt  = resp_data_r;
        resp_err_nxt   = resp_err_r;
        // one-cycle capture keeps all bits coherent
        if (query_i && !dev_clear)
        begin
            resp_valid_nxt = 1'b1;
            case (query_sel_i)
                CSR_Q_CRA: resp_data_nxt = cond_a;
                CSR_Q_CRB: resp_data_nxt = cond_b;
                CSR_Q_ERR:
                begin
                    resp_data_nxt = err_slots[7:0];
                    resp_err_nxt  = {err_slots,
                                     reset_source_register_i & RSTSRC_MASK};
                end
                CSR_Q_STB: resp_data_nxt = stb;
                default:   resp_data_nxt = REG_RESET;
            endcase
        end
        flush_nxt = dev_clear;
        ready_nxt = 1'b1;
        // message-available: set wins except a device clear forces it low
        mav_nxt = mav_r;
        if (msg_drained_i)
            mav_nxt = 1'b0;
        if (msg_set_i)
            mav_nxt = 1'b1;
        if (dev_clear)
            mav_nxt = 1'b0;
        summ_nxt = summ_r;
        if (clear_status_i)
            summ_nxt = 1'b0;
        if (status_summary_i)
            summ_nxt = 1'b1;
        srq_nxt = srq_r;
        if (clear_status_i || serial_poll_done_i)
            srq_nxt = 1'b0;
        if (srq_set_i)
            srq_nxt = 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            resp_valid_r <= 1'b0;
            resp_data_r  <= REG_RESET;
            resp_err_r   <= 32'h00000000;
            flush_r      <= 1'b0;
            ready_r      <= 1'b0;
            mav_r        <= 1'b0;
            srq_r        <= 1'b0;
            summ_r       <= 1'b0;
        end
        else
        begin
            resp_valid_r <= resp_valid_nxt;
            resp_data_r  <= resp_data_nxt;
            resp_err_r   <= resp_err_nxt;
            flush_r      <= flush_nxt;
            ready_r      <= ready_nxt;
            mav_r        <= mav_nxt;
            srq_r        <= srq_nxt;
            summ_r       <= summ_nxt;
        end
    end

    assign resp_valid_o            = resp_valid_r;
    assign resp_data_o             = resp_data_r;
    assign resp_err_list_o         = resp_err_r;
    assign buf_flush_o             = flush_r;
    assign ready_o                 = ready_r;
    assign message_available_bit_o = mav_r;
    assign srq_o                   = srq_r;
    // status byte view is not registered; it is composed from flops only
    always_comb
    begin
        status_byte_o = stb;
    end
endmodule

// file: design/csr_pkg.sv
// constants and types for the condition and status reporting block
// assumes a single 10 MHz core clock and synchronous active-low reset
package csr_pkg;
    localparam int unsigned CSR_REG_W       = 8;
    localparam int unsigned CSR_ERR_W       = 8;
    localparam int unsigned CSR_ERR_SLOTS   = 3;
    // condition register a field positions
    localparam int unsigned CRA_SEQ_BIT     = 7;
    localparam int unsigned CRA_OTSD_BIT    = 6;
    localparam int unsigned CRA_OTWARN_BIT  = 5;
    localparam int unsigned CRA_OVP_BIT     = 4;
    localparam int unsigned CRA_OCP_BIT     = 3;
    localparam int unsigned CRA_OL_BIT      = 2;
    localparam int unsigned CRA_CC_BIT      = 1;
    localparam int unsigned CRA_CV_BIT      = 0;
    // condition register b field positions
    localparam int unsigned CRB_TEST_BIT    = 7;
    localparam int unsigned CRB_TRIG2_BIT   = 6;
    localparam int unsigned CRB_TRIG1_BIT   = 5;
    localparam int unsigned CRB_MAINS_BIT   = 4;
    localparam int unsigned CRB_ZERO_BIT    = 3;
    localparam int unsigned CRB_SIG_BIT     = 2;
    localparam int unsigned CRB_IBAND_BIT   = 1;
    localparam int unsigned CRB_VBAND_BIT   = 0;
    // status byte
    localparam int unsigned STB_MAV_BIT     = 4;
    localparam int unsigned STB_RQS_BIT     = 6;
    localparam logic [7:0]  STB_RESET       = 8'h00;
    localparam logic [7:0]  ERR_EMPTY_CODE  = 8'h00;
    localparam logic [7:0]  RSTSRC_MASK     = 8'h1f;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    // query selectors
    typedef enum logic [1:0] {
        CSR_Q_CRA = 2'b00,
        CSR_Q_CRB = 2'b01,
        CSR_Q_ERR = 2'b10,
        CSR_Q_STB = 2'b11
    } csr_query_t;
endpackage

// file: design/csr_cond_regs.sv
// live condition registers a and b, sampled from external pins
// assumes condition inputs are asynchronous levels
`timescale 1ns/1ns
module csr_cond_regs
    import csr_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [7:0]           cond_a_raw_i,
    input  wire logic [7:0]           cond_b_raw_i,
    input  wire logic                 limit_monitor_enable_i,
    output logic      [7:0]           cond_a_o,
    output logic      [7:0]           cond_b_o
);
    logic [7:0] s1a_r, s1a_nxt, s2a_r, s2a_nxt;
    logic [7:0] s1b_r, s1b_nxt, s2b_r, s2b_nxt;
    logic       s1m_r, s1m_nxt, s2m_r, s2m_nxt;
    logic [7:0] cond_b_fix;

    always_comb
    begin
        s1a_nxt = cond_a_raw_i;
        s2a_nxt = s1a_r;
        s1b_nxt = cond_b_raw_i;
        s2b_nxt = s1b_r;
        s1m_nxt = limit_monitor_enable_i;
        s2m_nxt = s1m_r;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            s1a_r <= REG_RESET;
            s2a_r <= REG_RESET;
            s1b_r <= REG_RESET;
            s2b_r <= REG_RESET;
            s1m_r <= 1'b0;
            s2m_r <= 1'b0;
        end
        else
        begin
            s1a_r <= s1a_nxt;
            s2a_r <= s2a_nxt;
            s1b_r <= s1b_nxt;
            s2b_r <= s2b_nxt;
            s1m_r <= s1m_nxt;
            s2m_r <= s2m_nxt;
        end
    end

    // bits follow the condition both ways, band bits only while limit monitoring is on, bit 3 stays zero; nothing here is writable
    always_comb
    begin
        cond_b_fix = s2b_r;
        cond_b_fix[CRB_ZERO_BIT] = 1'b0;
        cond_b_fix[CRB_IBAND_BIT] = s2b_r[CRB_IBAND_BIT] & s2m_r;
        cond_b_fix[CRB_VBAND_BIT] = s2b_r[CRB_VBAND_BIT] & s2m_r;
    end

    assign cond_a_o = s2a_r;
    assign cond_b_o = cond_b_fix;
endmodule

// file: design/csr_error_list.sv
// error list: last three distinct codes by first entry, newest first; a repeat of a listed code is ignored
// assumes err_valid_i is a single-cycle pulse on the core clock
`timescale 1ns/1ns
module csr_error_list
    import csr_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 err_valid_i,
    input  wire logic [7:0]           err_code_i,
    input  wire logic                 clear_i,
    output logic      [23:0]          slots_o
);
    logic [7:0] slot_r   [CSR_ERR_SLOTS];
    logic [7:0] slot_nxt [CSR_ERR_SLOTS];
    logic       dup;

    always_comb
    begin
        dup = 1'b0;
        for (int i = 0; i < CSR_ERR_SLOTS; i++)
        begin
            slot_nxt[i] = slot_r[i];
            if (slot_r[i] == err_code_i)
                dup = 1'b1;
        end
        // a new error in the clear cycle survives the clear
        if (clear_i)
        begin
            for (int i = 0; i < CSR_ERR_SLOTS; i++)
                slot_nxt[i] = ERR_EMPTY_CODE;
        end
        if (err_valid_i && err_code_i != ERR_EMPTY_CODE && (clear_i || !dup))
        begin
            slot_nxt[0] = err_code_i;
            if (!clear_i)
            begin
                slot_nxt[1] = slot_r[0];
                slot_nxt[2] = slot_r[1];
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        for (int i = 0; i < CSR_ERR_SLOTS; i++)
        begin
            if (!rst_b_i)
                slot_r[i] <= ERR_EMPTY_CODE;
            else
                slot_r[i] <= slot_nxt[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < CSR_ERR_SLOTS; g++)
        begin : g_out
            assign slots_o[8*g +: 8] = slot_r[g];
        end
    endgenerate
endmodule

// file: verif/csr_status_monitor.sv
// checker on the status block top ports
// assumes one core clock and a sync active-low reset
`timescale 1ns/1ns
module csr_status_monitor
    import csr_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic [2:0] signal_outputs_i,
    input wire logic       limit_monitor_enable_i,
    input wire logic       query_i,
    input wire csr_query_t query_sel_i,
    input wire logic       text_clear_i,
    input wire logic       bus_sdc_i,
    input wire logic       bus_dcl_i,
    input wire logic       clear_status_i,
    input wire logic       srq_set_i,
    input wire logic       resp_valid_o,
    input wire logic [7:0] resp_data_o,
    input wire logic       buf_flush_o,
    input wire logic       ready_o,
    input wire logic       message_available_bit_o,
    input wire logic       srq_o,
    input wire logic [7:0] status_byte_o
);
    wire dc = text_clear_i | bus_sdc_i | bus_dcl_i;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_take;
        query_i && !dc;
    endsequence
    sequence s_qb;
        s_take ##0 query_sel_i == CSR_Q_CRB;
    endsequence
    // pins need two edges to land, so four stable samples before the query
    sequence s_sig_held;
        $stable(signal_outputs_i)[*4];
    endsequence
    property p_answer; s_take |=> resp_valid_o; endproperty
    property p_refuse; !(query_i && !dc) |=> !resp_valid_o; endproperty
    property p_flush; dc |=> buf_flush_o; endproperty
    property p_noflush; !dc |=> !buf_flush_o; endproperty
    property p_mav; dc |=> !message_available_bit_o; endproperty
    property p_stb;
        status_byte_o[STB_MAV_BIT] == message_available_bit_o && status_byte_o[STB_RQS_BIT] == srq_o;
    endproperty
    property p_cls; clear_status_i && !srq_set_i |=> !srq_o; endproperty
    property p_zero; s_qb |=> !resp_data_o[CRB_ZERO_BIT]; endproperty
    property p_sig;
        s_sig_held ##0 s_qb |=> resp_data_o[CRB_SIG_BIT] == |$past(signal_outputs_i);
    endproperty
    property p_band; (!limit_monitor_enable_i)[*4] ##0 s_qb |=> resp_data_o[1:0] == 2'b00;
    endproperty
    property p_ready; 1'b1 |=> ready_o; endproperty
    a_answer: assert property (p_answer) else $error("query not answered");
    a_refuse: assert property (p_refuse) else $error("stray response");
    a_flush: assert property (p_flush) else $error("no buffer flush");
    a_noflush: assert property (p_noflush) else $error("stray buffer flush");
    a_mav: assert property (p_mav) else $error("message bit kept");
    a_stb: assert property (p_stb) else $error("status byte bits differ");
    a_cls: assert property (p_cls) else $error("request kept");
    a_zero: assert property (p_zero) else $error("b bit 3 set");
    a_sig: assert property (p_sig) else $error("signal or wrong");
    a_band: assert property (p_band) else $error("band bits while off");
    a_ready: assert property (p_ready) else $error("not ready");
endmodule
bind csr_status_top csr_status_monitor u_mon (.*);

// file: verif/csr_host.sv
// host side model issuing queries and clears
// assumes strobes are one core clock wide, driven at the falling edge
`timescale 1ns/1ns
module csr_host
    import csr_pkg::*;
(
    input  wire logic core_clk_i,
    output logic       query_o,
    output csr_query_t sel_o,
    output logic [2:0] dclr_o,
    output logic       cls_o
);
    initial {query_o, dclr_o, cls_o} = 5'h00;
    initial sel_o = CSR_Q_CRA;
    task automatic query(input csr_query_t s);
        @(negedge core_clk_i);
        query_o = 1'b1;
        sel_o = s;
        @(negedge core_clk_i);
        query_o = 1'b0;
    endtask
    // text, addressed and universal clear; q adds a query that must be dropped
    task automatic clear(input int k, input logic q);
        @(negedge core_clk_i);
        dclr_o = 3'h1 << k;
        query_o = q;
        @(negedge core_clk_i);
        dclr_o = 3'h0;
        query_o = 1'b0;
    endtask
    task automatic clr_status;
        @(negedge core_clk_i);
        cls_o = 1'b1;
        @(negedge core_clk_i);
        cls_o = 1'b0;
    endtask
endmodule

// file: verif/condition_status_reporting_bench.sv
// bench for the status block with a queue model of the error list
// assumes csr_host drives the command side, the bench drives all pins
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module condition_status_reporting_bench;
    import csr_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] ca, cbv, err_code_i, reset_source_register_i, resp_data_o, status_byte_o;
    logic [2:0] signal_outputs_i;
    logic       limit_monitor_enable_i, err_valid_i, msg_set_i, status_summary_i;
    logic       srq_set_i, serial_poll_done_i, msg_drained_i, query_i, clear_status_i;
    logic       resp_valid_o, buf_flush_o, ready_o, message_available_bit_o, srq_o;
    logic [31:0] resp_err_list_o;
    csr_query_t query_sel_i;
    wire        seq_running_i, overtemp_shutdown_i, overtemp_warning_i, overvoltage_prot_i;
    wire        overcurrent_prot_i, overload_i, current_regulation_i, voltage_regulation_i;
    wire        selftest_or_calibration_i, trigger_input_two_i, trigger_input_one_i;
    wire        mains_low_i, current_band_violation_i, voltage_band_violation_i;
    wire        text_clear_i, bus_sdc_i, bus_dcl_i;
    int         err_total = 0, compares = 0, seed = 32'h30df, i, k;
    int         errq[$];
    logic [31:0] exp_l;
    logic [7:0] codes[6] = '{8'h1f, 8'h62, 8'h1f, 8'h00, 8'h05, 8'h07};
    assign {seq_running_i, overtemp_shutdown_i, overtemp_warning_i, overvoltage_prot_i,
            overcurrent_prot_i, overload_i, current_regulation_i, voltage_regulation_i} = ca;
    assign {selftest_or_calibration_i, trigger_input_two_i, trigger_input_one_i,
            mains_low_i} = cbv[7:4];
    assign {current_band_violation_i, voltage_band_violation_i} = cbv[1:0];
    csr_status_top DUT (.*);
    csr_host host (
        .core_clk_i (core_clk_i),
        .query_o    (query_i),
        .sel_o      (query_sel_i),
        .dclr_o     ({bus_dcl_i, bus_sdc_i, text_clear_i}),
        .cls_o      (clear_status_i)
    );
    always #50 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] elist();
        logic [31:0] r;
        r = {24'h0, reset_source_register_i & RSTSRC_MASK};
        foreach (errq[j]) r[8*(j+1) +: 8] = errq[j][7:0];
        return r;
    endfunction
    task automatic pulse(ref logic s);
        @(negedge core_clk_i);
        s = 1'b1;
        @(negedge core_clk_i);
        s = 1'b0;
    endtask
    task automatic conclude;
        $display("compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #1000000;
        err_total++;
        conclude();
    end
    initial
    begin
        {ca, cbv, err_code_i, signal_outputs_i, limit_monitor_enable_i} = '0;
        {err_valid_i, msg_set_i, status_summary_i, srq_set_i, serial_poll_done_i} = '0;
        msg_drained_i = 1'b0;
        reset_source_register_i = $random(seed);
        repeat (5) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        `CHK(ready_o, 1'b1)
        `CHK(status_byte_o, STB_RESET)
        for (i = 0; i < 24; i++)
        begin
            ca = (i == 0) ? 8'hff : $random(seed);
            cbv = (i == 1) ? 8'hff : $random(seed);
            signal_outputs_i = $random(seed);
            limit_monitor_enable_i = $random(seed);
            repeat (4) @(negedge core_clk_i);
            host.query(CSR_Q_CRA);
            `CHK(resp_valid_o, 1'b1)
            `CHK(resp_data_o, ca)
            host.query(CSR_Q_CRB);
            `CHK(resp_data_o, {cbv[7:4], 1'b0, |signal_outputs_i,
                 limit_monitor_enable_i ? cbv[1:0] : 2'b00})
            host.query(CSR_Q_CRA);
            `CHK(resp_data_o, ca)
        end
        for (i = 0; i < 6; i++)
        begin
            err_code_i = codes[i];
            pulse(err_valid_i);
            if (codes[i] != 0 && !(codes[i] inside {errq}))
                errq.push_front(codes[i]);
            if (errq.size() > 3)
                void'(errq.pop_back());
            host.query(CSR_Q_ERR);
            exp_l = elist();
            `CHK(resp_err_list_o, exp_l)
            `CHK(resp_data_o, exp_l[15:8])
        end
        for (k = 0; k < 3; k++)
        begin
            pulse(msg_set_i);
            `CHK(message_available_bit_o, 1'b1)
            host.clear(k, k == 2);
            `CHK(buf_flush_o, 1'b1)
            `CHK(resp_valid_o, 1'b0)
            `CHK(message_available_bit_o, 1'b0)
            @(negedge core_clk_i);
            `CHK(buf_flush_o, 1'b0)
        end
        host.query(CSR_Q_ERR);
        `CHK(resp_err_list_o, elist())
        pulse(msg_set_i);
        pulse(status_summary_i);
        pulse(srq_set_i);
        `CHK(status_byte_o, 8'h51)
        host.clr_status();
        errq.delete();
        `CHK(status_byte_o, 8'h10)
        host.query(CSR_Q_ERR);
        `CHK(resp_err_list_o, elist())
        pulse(msg_drained_i);
        `CHK(message_available_bit_o, 1'b0)
        pulse(srq_set_i);
        pulse(serial_poll_done_i);
        `CHK(srq_o, 1'b0)
        conclude();
    end
endmodule
